// >>> rtl/bepc_pkg.sv
//=============================================================================
// Purpose : shared constants for the bus event performance counters
// Assumes : 32-bit register bus, byte addresses, 12-bit register window
// Notes   : select codes are shared by both event counters
//=============================================================================
package bepc_pkg;

    //=========================================================================
    // bus geometry
    localparam int DATA_W = 32;
    localparam int ADDR_W = 12;
    localparam int BE_W   = DATA_W / 8;

    //=========================================================================
    // register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] OFS_CTRL      = 12'hf00;
    localparam logic [ADDR_W-1:0] OFS_CNT0      = 12'hf10;
    localparam logic [ADDR_W-1:0] OFS_CNT1      = 12'hf14;
    localparam logic [ADDR_W-1:0] OFS_MISS_ADDR = 12'hf18;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT  = 12'hf1c;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK  = 12'hf20;
    localparam logic [ADDR_W-1:0] OFS_MISS_FREQ = 12'hf24;

    //=========================================================================
    // control register layout
    localparam int NMASK_LSB   = 24;
    localparam int NMASK_W     = 8;
    localparam int C1_STOP_BIT = 23;
    localparam int C1_GO_BIT   = 22;
    localparam int C1_SEL_LSB  = 16;
    localparam int C0_STOP_BIT = 15;
    localparam int C0_GO_BIT   = 14;
    localparam int C0_SEL_LSB  = 8;
    localparam int SEL_W       = 5;
    localparam logic [DATA_W-1:0] CTRL_RW_MASK = 32'hff1f_1f00;
    localparam logic [DATA_W-1:0] CTRL_RESET   = 32'h0000_0000;

    //=========================================================================
    // interrupt status layout and other widths
    localparam int STAT_OVF0   = 0;
    localparam int STAT_OVF1   = 1;
    localparam int STAT_W      = 2;
    localparam int MISS_FREQ_W = 8;
    localparam int NODE_W      = 3;
    localparam int EV_IN_W     = 20;

    //=========================================================================
    // event select codes
    typedef enum logic [SEL_W-1:0] {
        EV_READ_MISS   = 5'h00,
        EV_WRITE_MISS  = 5'h01,
        EV_SHARED_MISS = 5'h02,
        EV_LOAD_LOCKED = 5'h03,
        EV_STC_FAIL    = 5'h04,
        EV_MAP_HIT     = 5'h05,
        EV_BANK_DELAY  = 5'h06,
        EV_ARB_LOSS    = 5'h07,
        EV_VB_HIT      = 5'h08,
        EV_REG_READ    = 5'h09,
        EV_REG_WRITE   = 5'h0a,
        EV_MBOX_WRITE  = 5'h0b,
        EV_BUS_IRQ     = 5'h0c,
        EV_LOCAL_READ  = 5'h0d,
        EV_LOCAL_WRITE = 5'h0e,
        EV_BUS_READ    = 5'h0f,
        EV_BUS_WRITE   = 5'h10,
        EV_VICTIM_WR   = 5'h11,
        EV_STALL       = 5'h12,
        EV_MEM_LATENCY = 5'h13,
        EV_CARRY       = 5'h14
    } bepc_event_type;

endpackage

// >>> rtl/bepc_event_select.sv
//=============================================================================
// Purpose : picks the one event that an event counter advances on
// Assumes : all inputs synchronous to the counter clock
// Notes   : purely combinational; the counter registers the result
//=============================================================================
`timescale 1ns/1ps
`default_nettype none

module bepc_event_select
#(
    parameter bit SECOND = 1'b0
)
(
    input  wire logic [bepc_pkg::SEL_W-1:0]   selCode,
    input  wire logic [bepc_pkg::EV_IN_W-1:0] evtIn,
    input  wire logic                         vbHit,
    input  wire logic                         vbWrap,
    input  wire logic                         busRead,
    input  wire logic                         busWrite,
    input  wire logic                         victimWrite,
    input  wire logic                         nodeMatch,
    input  wire logic                         carryIn,
    output logic                              hit
);
    import bepc_pkg::*;

    //=========================================================================
    // event decode; unlisted codes leave the counter still
    always_comb
    begin
        hit = 1'b0;
        case (selCode)
            EV_VB_HIT:
                hit = SECOND ? (vbHit && vbWrap) : vbHit;
            EV_BUS_READ:
                hit = busRead && nodeMatch;
            EV_BUS_WRITE:
                hit = busWrite && nodeMatch;
            EV_VICTIM_WR:
                hit = victimWrite && nodeMatch;
            EV_CARRY:
                hit = carryIn;
            EV_BUS_IRQ, EV_LOCAL_WRITE:
                hit = SECOND ? 1'b0 : evtIn[selCode];
            default:
            begin
                // codes beyond the carry code are reserved
                if (selCode < EV_CARRY)
                    hit = evtIn[selCode];
                else
                    hit = 1'b0;
            end
        endcase
    end

endmodule

`default_nettype wire

// >>> rtl/bepc_counter.sv
//=============================================================================
// Purpose : one event counter with load, run gate and carry-out pulse
// Assumes : load from the register bus wins over counting
// Notes   : carry is registered so two counters may cascade loop-free
//=============================================================================
`timescale 1ns/1ps
`default_nettype none

module bepc_counter
#(
    parameter int WIDTH = 32
)
(
    input  wire logic             ref_clk,
    input  wire logic             srst,
    input  wire logic             run,
    input  wire logic             inc,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] loadVal,
    output logic      [WIDTH-1:0] count,
    output logic                  carry
);
    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic             carry;
    } bepc_cnt_state_type;

    bepc_cnt_state_type st_q;
    bepc_cnt_state_type st_d;

    //=========================================================================
    // next count; carry is a one-cycle pulse on wrap to zero
    always_comb
    begin
        st_d       = st_q;
        st_d.carry = 1'b0;
        if (load)
            st_d.count = loadVal;
        else if (run && inc)
        begin
            st_d.count = st_q.count + 1'b1;
            st_d.carry = &st_q.count;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign count = st_q.count;
    assign carry = st_q.carry;

endmodule

`default_nettype wire

// >>> rtl/bepc_perf_counters.sv
//=============================================================================
// Purpose : control register, two event counters and miss address capture
// Assumes : Avalon-MM slave with waitrequest, byte addresses, ref_clk only
// Notes   : every request is answered; unmapped reads return zero
//=============================================================================
// Summary of operation
// - node mask in control bits 31:24, bit 31 is node 7 downward
// - lowest mask bit covers node 0 and the I/O processor together
// - only bus reads, writes and victim writes pass the node mask
// - one node mask filters both event counters
// - writing one to bit 23 stops counter 1; reads as zero
// - writing one to bit 22 starts counter 1; reads as zero
// - control bit 21 is reserved and reads zero
// - bits 20:16 select counter 1 event, codes 0 to 4 misses and locks
// - codes 5, 6, 7 count map hits, bank delays, arbitration losses
// - codes 9, 10, 11, 13 count register and local bus accesses
// - codes 18, 19 stall and latency; 15 to 17 node-masked traffic
// - counter 1 code 20 counts counter 0 carry-outs, cascading
// - counter 1 code 8 counts only wrapped victim buffer hits
// - counter 0 code 8 counts every victim buffer hit
// - each counter has own select, start, stop and overflow bit
// - miss address captured at a rate set by a frequency field
// - bits 15, 14 stop and start counter 0; bits 12:8 select
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none

module bepc_perf_counters
#(
    parameter int CNT_W = 32
)
(
    input  wire logic                           ref_clk,
    input  wire logic                           srst,
    input  wire logic [bepc_pkg::ADDR_W-1:0]    address,
    input  wire logic                           read,
    input  wire logic                           write,
    input  wire logic [bepc_pkg::DATA_W-1:0]    writedata,
    input  wire logic [bepc_pkg::BE_W-1:0]      byteenable,
    output logic      [bepc_pkg::DATA_W-1:0]    readdata,
    output logic                                waitrequest,
    output logic                                irq,
    input  wire logic [bepc_pkg::EV_IN_W-1:0]   evtIn,
    input  wire logic                           vbHit,
    input  wire logic                           vbWrap,
    input  wire logic                           busRead,
    input  wire logic                           busWrite,
    input  wire logic                           victimWrite,
    input  wire logic [bepc_pkg::NODE_W-1:0]    srcNode,
    input  wire logic                           srcIop,
    input  wire logic                           missStrobe,
    input  wire logic [bepc_pkg::DATA_W-1:0]    missAddrIn
);
    import bepc_pkg::*;

    //=========================================================================
    // module state
    typedef struct packed {
        logic [DATA_W-1:0]      ctrl;
        logic                   run0;
        logic                   run1;
        logic [STAT_W-1:0]      stat;
        logic [STAT_W-1:0]      mask;
        logic [MISS_FREQ_W-1:0] missFreq;
        logic [MISS_FREQ_W-1:0] missCnt;
        logic [DATA_W-1:0]      missAddr;
        logic                   waitReq;
        logic [DATA_W-1:0]      rdData;
        logic                   irq;
    } bepc_state_type;

    bepc_state_type st_q;
    bepc_state_type st_d;

    logic [DATA_W-1:0] beMask;
    logic [DATA_W-1:0] wrBits;
    logic              wrAccept;
    logic              rdStart;
    logic [DATA_W-1:0] rdMux;
    logic              nodeMatch;
    logic [SEL_W-1:0]  sel0;
    logic [SEL_W-1:0]  sel1;
    logic              hit0;
    logic              hit1;
    logic [CNT_W-1:0]  count0;
    logic [CNT_W-1:0]  count1;
    logic              carry0;
    logic              carry1;
    logic              load0;
    logic              load1;
    logic [CNT_W-1:0]  loadVal0;
    logic [CNT_W-1:0]  loadVal1;

    //=========================================================================
    // byte lane mask, one byte of ones per enabled lane
    genvar gi;
    generate
        for (gi = 0; gi < BE_W; gi++)
        begin : g_lane
            assign beMask[gi*8 +: 8] = {8{byteenable[gi]}};
        end
    endgenerate

    //=========================================================================
    // bus handshake: a write lands at the edge where waitrequest is low
    assign wrAccept = write && !st_q.waitReq;
    assign rdStart  = read && st_q.waitReq;
    assign wrBits   = writedata & beMask;

    //=========================================================================
    // node filter; the I/O processor shares the lowest mask bit
    always_comb
    begin
        if (srcIop)
            nodeMatch = st_q.ctrl[NMASK_LSB];
        else
            nodeMatch = st_q.ctrl[NMASK_LSB + int'(srcNode)];
    end

    assign sel0 = st_q.ctrl[C0_SEL_LSB +: SEL_W];
    assign sel1 = st_q.ctrl[C1_SEL_LSB +: SEL_W];

    //=========================================================================
    // counter loads from the bus honour byte enables
    assign load0    = wrAccept && (address == OFS_CNT0);
    assign load1    = wrAccept && (address == OFS_CNT1);
    assign loadVal0 = (count0 & ~beMask) | wrBits;
    assign loadVal1 = (count1 & ~beMask) | wrBits;

    //=========================================================================
    // event selection, both fed by the same node match
    bepc_event_select #(
        .SECOND      (1'b0)
    ) u_sel0 (
        .selCode     (sel0),
        .evtIn       (evtIn),
        .vbHit       (vbHit),
        .vbWrap      (vbWrap),
        .busRead     (busRead),
        .busWrite    (busWrite),
        .victimWrite (victimWrite),
        .nodeMatch   (nodeMatch),
        .carryIn     (carry1),
        .hit         (hit0)
    );

    bepc_event_select #(
        .SECOND      (1'b1)
    ) u_sel1 (
        .selCode     (sel1),
        .evtIn       (evtIn),
        .vbHit       (vbHit),
        .vbWrap      (vbWrap),
        .busRead     (busRead),
        .busWrite    (busWrite),
        .victimWrite (victimWrite),
        .nodeMatch   (nodeMatch),
        .carryIn     (carry0),
        .hit         (hit1)
    );

    //=========================================================================
    // the two counters; each has its own run flag
    bepc_counter #(
        .WIDTH   (CNT_W)
    ) u_cnt0 (
        .ref_clk (ref_clk),
        .srst    (srst),
        .run     (st_q.run0),
        .inc     (hit0),
        .load    (load0),
        .loadVal (loadVal0),
        .count   (count0),
        .carry   (carry0)
    );

    bepc_counter #(
        .WIDTH   (CNT_W)
    ) u_cnt1 (
        .ref_clk (ref_clk),
        .srst    (srst),
        .run     (st_q.run1),
        .inc     (hit1),
        .load    (load1),
        .loadVal (loadVal1),
        .count   (count1),
        .carry   (carry1)
    );

    //=========================================================================
    // read mux; start/stop and reserved bits never hold state, so read zero
    always_comb
    begin
        rdMux = '0;
        case (address)
            OFS_CTRL:      rdMux = st_q.ctrl & CTRL_RW_MASK;
            OFS_CNT0:      rdMux = DATA_W'(count0);
            OFS_CNT1:      rdMux = DATA_W'(count1);
            OFS_MISS_ADDR: rdMux = st_q.missAddr;
            OFS_IRQ_STAT:  rdMux = DATA_W'(st_q.stat);
            OFS_IRQ_MASK:  rdMux = DATA_W'(st_q.mask);
            OFS_MISS_FREQ: rdMux = DATA_W'(st_q.missFreq);
            default:       rdMux = '0;
        endcase
    end

    //=========================================================================
    // next state
    always_comb
    begin
        st_d = st_q;

        // one wait cycle, then one ready cycle per request
        st_d.waitReq = !rdStart && !(write && st_q.waitReq);
        if (rdStart)
            st_d.rdData = rdMux;

        if (wrAccept && (address == OFS_CTRL))
        begin
            st_d.ctrl = (st_q.ctrl & ~(beMask & CTRL_RW_MASK))
                      | (wrBits & CTRL_RW_MASK);
            // a zero in a start or stop bit does nothing; stop wins
            if (wrBits[C0_GO_BIT])
                st_d.run0 = 1'b1;
            if (wrBits[C0_STOP_BIT])
                st_d.run0 = 1'b0;
            if (wrBits[C1_GO_BIT])
                st_d.run1 = 1'b1;
            if (wrBits[C1_STOP_BIT])
                st_d.run1 = 1'b0;
        end

        if (wrAccept && (address == OFS_IRQ_MASK))
            st_d.mask = wrBits[STAT_W-1:0];
        if (wrAccept && (address == OFS_MISS_FREQ))
        begin
            st_d.missFreq = wrBits[MISS_FREQ_W-1:0];
            st_d.missCnt  = '0;
        end

        // overflow flags: clear by writing one, a new overflow wins
        if (wrAccept && (address == OFS_IRQ_STAT))
            st_d.stat = st_q.stat & ~wrBits[STAT_W-1:0];
        if (carry0)
            st_d.stat[STAT_OVF0] = 1'b1;
        if (carry1)
            st_d.stat[STAT_OVF1] = 1'b1;

        // capture every missFreq-th miss; zero disables capture
        if (missStrobe && (st_q.missFreq != '0))
        begin
            if (st_q.missCnt == st_q.missFreq - 1'b1)
            begin
                st_d.missAddr = missAddrIn;
                st_d.missCnt  = '0;
            end
            else
                st_d.missCnt = st_q.missCnt + 1'b1;
        end

        st_d.irq = |(st_d.stat & st_d.mask);
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            st_q         <= '0;
            st_q.ctrl    <= CTRL_RESET;
            st_q.waitReq <= 1'b1;
        end
        else
            st_q <= st_d;
    end

    assign readdata    = st_q.rdData;
    assign waitrequest = st_q.waitReq;
    assign irq         = st_q.irq;

    //=========================================================================
    // checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    logic ctrlWr;
    assign ctrlWr = wrAccept && (address == OFS_CTRL);

    stop_one_a: assert property (ctrlWr && wrBits[C1_STOP_BIT]
                                 |=> !st_q.run1)
        else $error("counter 1 still running after stop");
    go_one_a: assert property (ctrlWr && wrBits[C1_GO_BIT]
                               && !wrBits[C1_STOP_BIT] |=> st_q.run1)
        else $error("counter 1 not running after start");
    stop_zero_a: assert property (ctrlWr && wrBits[C0_STOP_BIT]
                                  |=> !st_q.run0)
        else $error("counter 0 still running after stop");
    run_hold_a: assert property (ctrlWr && !wrBits[C0_GO_BIT]
                                 && !wrBits[C0_STOP_BIT]
                                 |=> st_q.run0 == $past(st_q.run0))
        else $error("counter 0 run flag moved without a one");
    rsvd_read_a: assert property ($fell(waitrequest) && $past(read)
                                  && $past(address) == OFS_CTRL
                                  |-> readdata[21] == 1'b0
                                  && readdata[13] == 1'b0
                                  && readdata[C1_GO_BIT] == 1'b0)
        else $error("reserved or write-only control bit read as one");
    cascade_a: assert property (st_q.run1 && sel1 == EV_CARRY
                                && carry0 && !load1
                                |=> count1 == $past(count1) + 1'b1)
        else $error("counter 1 missed a carry from counter 0");
    wrap_only_a: assert property (sel1 == EV_VB_HIT && vbHit
                                  && !vbWrap |-> !hit1)
        else $error("counter 1 took an unwrapped victim hit");
    all_hits_a: assert property (sel0 == EV_VB_HIT && vbHit |-> hit0)
        else $error("counter 0 missed a victim hit");
    node_filter_a: assert property (sel1 == EV_BUS_READ && busRead
                                    && !nodeMatch |-> !hit1)
        else $error("bus read counted for a masked node");
    iop_mask_a: assert property (srcIop |-> nodeMatch ==
                                 st_q.ctrl[NMASK_LSB])
        else $error("I/O processor not tied to lowest mask bit");
    reserved_a: assert property (sel1 > EV_CARRY |-> !hit1)
        else $error("reserved select code counted");
    overflow_a: assert property (carry1 |=> st_q.stat[STAT_OVF1]
                                 ##1 irq == |(st_q.stat & st_q.mask))
        else $error("overflow flag or interrupt wrong");
    ovf_zero_a: assert property (carry0
                                 |=> st_q.stat[STAT_OVF0])
        else $error("counter 0 overflow flag not set");
    miss_cap_a: assert property (missStrobe && st_q.missFreq == 8'h02
                                 && st_q.missCnt == 8'h01
                                 |=> st_q.missAddr == $past(missAddrIn))
        else $error("second miss address not captured");

    cascade_c: cover property (st_q.run1 && sel1 == EV_CARRY && carry0);
    vb_hit_c: cover property (vbHit && hit0 && !hit1);
    masked_c: cover property (sel0 == EV_BUS_WRITE && busWrite && hit0);
    irq_c: cover property ($rose(irq));
    miss_c: cover property (missStrobe && st_q.missCnt != '0);

endmodule

`default_nettype wire

// >>> testbench/bus_event_perf_counters_bench.sv
// Purpose : self-checking bench for the bus event performance counters
// Assumes : avalon slave answers after one wait cycle, byteenable all ones
// Notes   : events are driven as strobes; expectations come from the rules
`timescale 1ns/1ps
`default_nettype none
module bus_event_perf_counters_bench;
    import bepc_pkg::*;
    logic                 ref_clk = 1'b0;
    logic                 srst = 1'b1;
    logic [ADDR_W-1:0]    address = '0;
    logic                 read = 1'b0;
    logic                 write = 1'b0;
    logic [DATA_W-1:0]    writedata = '0;
    logic [DATA_W-1:0]    readdata;
    logic                 waitrequest;
    logic                 irq;
    logic [EV_IN_W-1:0]   evtIn = '0;
    logic                 vbHit = 1'b0;
    logic                 vbWrap = 1'b0;
    logic                 busRead = 1'b0;
    logic                 busWrite = 1'b0;
    logic                 victimWrite = 1'b0;
    logic [NODE_W-1:0]    srcNode = '0;
    logic                 srcIop = 1'b0;
    logic                 missStrobe = 1'b0;
    logic [DATA_W-1:0]    missAddrIn = '0;
    int                   failCount = 0;
    int                   testsRun = 0;
    logic [DATA_W-1:0]    selw;
    logic [4:0]           codes [16] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04,
        5'h05, 5'h06, 5'h07, 5'h09, 5'h0a, 5'h0b, 5'h0d, 5'h12, 5'h13,
        5'h0c, 5'h0e};
    //==========================================================================
    // clock, dut
    always #2.5 ref_clk = ~ref_clk;
    bepc_perf_counters bepc_perf_counters_inst (.ref_clk(ref_clk),
        .srst(srst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(4'hf), .readdata(readdata),
        .waitrequest(waitrequest), .irq(irq), .evtIn(evtIn), .vbHit(vbHit),
        .vbWrap(vbWrap), .busRead(busRead), .busWrite(busWrite),
        .victimWrite(victimWrite), .srcNode(srcNode), .srcIop(srcIop),
        .missStrobe(missStrobe), .missAddrIn(missAddrIn));
    //==========================================================================
    // verdict, printed in one place only
    task automatic completeRun();
        if (failCount == 0 && testsRun > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp)
        begin
            failCount++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    //==========================================================================
    // avalon master: request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge ref_clk);
        read <= ~wr;
        write <= wr;
        address <= a;
        writedata <= d;
        // no fixed latency assumed; only the watchdog ends a lost wait
        do
        begin
            @(posedge ref_clk);
        end
        while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q, exp);
    endtask
    // one event strobe held for n cycles
    task automatic evt(input int c, input int n);
        @(posedge ref_clk);
        evtIn <= 20'h1 << c;
        repeat (n) @(posedge ref_clk);
        evtIn <= '0;
        repeat (2) @(posedge ref_clk);
    endtask
    // one bus transaction of kind k from a node
    task automatic tx(input int k, input logic [2:0] nd, input logic io_processor_module);
        @(posedge ref_clk);
        busRead <= (k == 0);
        busWrite <= (k == 1);
        victimWrite <= (k == 2);
        srcNode <= nd;
        srcIop <= io_processor_module;
        @(posedge ref_clk);
        {busRead, busWrite, victimWrite, srcIop} <= 4'h0;
    endtask
    //==========================================================================
    // watchdog: the whole sequence needs well under 10000 cycles
    initial
    begin
        #200000;
        failCount++;
        completeRun();
    end
    initial
    begin
        repeat (6) @(posedge ref_clk);
        srst <= 1'b0;
        rdchk(OFS_CTRL, 32'h0);
        wr(OFS_CTRL, 32'hffff_ffff);
        rdchk(OFS_CTRL, 32'hff1f_1f00);
        rdchk(12'hf04, 32'h0);
        // every listed code counts; go, no-op write, stop; codes 12 and 14 leave counter 1 at 0
        foreach (codes[i])
        begin
            wr(OFS_CNT0, 32'h0);
            wr(OFS_CNT1, 32'h0);
            selw = {11'h0, codes[i], 3'h0, codes[i], 8'h0};
            wr(OFS_CTRL, 32'h0040_4000 | selw);
            evt(codes[i], 3);
            wr(OFS_CTRL, selw);
            evt(codes[i], 2);
            wr(OFS_CTRL, 32'h0080_8000 | selw);
            evt(codes[i], 4);
            rdchk(OFS_CNT0, 32'h5);
            rdchk(OFS_CNT1, (i < 14) ? 32'h5 : 32'h0);
        end
        // victim buffer hits: counter 0 all, counter 1 wrapped only
        wr(OFS_CNT0, 32'h0);
        wr(OFS_CNT1, 32'h0);
        wr(OFS_CTRL, 32'h0048_4800);
        for (int i = 0; i < 3; i++)
        begin
            @(posedge ref_clk);
            vbHit <= 1'b1;
            vbWrap <= (i == 1);
            @(posedge ref_clk);
            {vbHit, vbWrap} <= 2'b00;
        end
        repeat (2) @(posedge ref_clk);
        rdchk(OFS_CNT0, 32'h3);
        rdchk(OFS_CNT1, 32'h1);
        // node mask: nodes 7 and 0 (with io processor) on, node 3 off
        for (int k = 0; k < 3; k++)
        begin
            wr(OFS_CNT0, 32'h0);
            wr(OFS_CNT1, 32'h0);
            selw = ((32'h0f + k) << 16) | ((32'h0f + k) << 8);
            wr(OFS_CTRL, 32'h8140_4000 | selw);
            tx(k, 3'd7, 1'b0);
            tx(k, 3'd3, 1'b0);
            tx(k, 3'd0, 1'b0);
            tx(k, 3'd5, 1'b1);
            repeat (2) @(posedge ref_clk);
            rdchk(OFS_CNT0, 32'h3);
            rdchk(OFS_CNT1, 32'h3);
        end
        // cascade and overflow interrupt: raise, mask, clear
        wr(OFS_CNT0, 32'hffff_fffe);
        // counter 1 starts at all ones so the cascade wraps it as well
        wr(OFS_CNT1, 32'hffff_ffff);
        wr(OFS_IRQ_MASK, 32'h1);
        wr(OFS_CTRL, 32'h0054_4000);
        evt(0, 2);
        repeat (4) @(posedge ref_clk);
        rdchk(OFS_CNT1, 32'h0);
        rdchk(OFS_IRQ_STAT, 32'h3);
        check({31'h0, irq}, 32'h1);
        wr(OFS_IRQ_MASK, 32'h0);
        repeat (2) @(posedge ref_clk);
        check({31'h0, irq}, 32'h0);
        wr(OFS_IRQ_STAT, 32'h3);
        rdchk(OFS_IRQ_STAT, 32'h0);
        // miss address: every second miss is captured
        wr(OFS_MISS_FREQ, 32'h2);
        for (int i = 1; i <= 4; i++)
        begin
            @(posedge ref_clk);
            missStrobe <= 1'b1;
            missAddrIn <= 32'h1000_0000 + i * 16;
            @(posedge ref_clk);
            missStrobe <= 1'b0;
        end
        repeat (2) @(posedge ref_clk);
        rdchk(OFS_MISS_ADDR, 32'h1000_0040);
        completeRun();
    end
endmodule
`default_nettype wire
